// >>> design/cfpc_consts.vh
// cfpc_consts.vh: register map, field positions, limits and reset values
// assumes: included by the configuration block, 32-bit APB data
`ifndef CFPC_CONSTS_VH
`define CFPC_CONSTS_VH
`define CFPC_OFS_CTRL0      12'h000
`define CFPC_OFS_ARB0       12'h004
`define CFPC_OFS_DATA0      12'h008
`define CFPC_OFS_SP0        12'h00C
`define CFPC_OFS_CTRL1      12'h010
`define CFPC_OFS_ARB1       12'h014
`define CFPC_OFS_DATA1      12'h018
`define CFPC_OFS_SP1        12'h01C
`define CFPC_OFS_CONNECT    12'h020
`define CFPC_OFS_STATUS     12'h024
`define CFPC_OFS_RXFIFO     12'h028
`define CFPC_BIT_ENABLE     0
`define CFPC_BIT_MONITOR    1
`define CFPC_BIT_LEGACY     2
`define CFPC_BIT_CONNECT    0
`define CFPC_BIT_DISCONNECT 1
`define CFPC_RATE_W         12
`define CFPC_SP_W           14
`define CFPC_ARB_MIN        12'h00A
`define CFPC_ARB_MAX        12'h3E8
`define CFPC_DATA_MIN       12'h064
`define CFPC_DATA_MAX       12'hBB8
`define CFPC_SP_MIN         14'h0001
`define CFPC_SP_MAX         14'h270F
`define CFPC_ARB_RESET      12'h1F4
`define CFPC_DATA_RESET     12'h7D0
`define CFPC_SP_RESET       14'h1F40
`define CFPC_FIFO_W         32
`define CFPC_FIFO_DEPTH     4
`define CFPC_FIFO_AW        2
`endif

// >>> design/cfpc_fifo.v
// cfpc_fifo.v: holds no logic of its own
// assumes: the receive FIFO module cfpc_fifo is defined in cfpc_port_config.v

// >>> design/cfpc_port_config.v
// cfpc_port_config.v: receive FIFO, APB-configured mode and bit timing for two CAN FD ports
// assumes: APB master on clk_sys, CAN controllers consume the port outputs
`timescale 1ns/100ps
`include "cfpc_consts.vh"

// flip-flop FIFO with valid/ready on both sides
module cfpc_fifo
#(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW    = 2
)
(
    input  wire             clk_sys,
    input  wire             reset,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    output wire [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady
);
    localparam [AW:0] FULL_COUNT = DEPTH;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr;
    reg [AW-1:0]    rdPtr;
    reg [AW:0]      count;
    reg [AW:0]      next_count;
    reg             readyReg;
    wire            doWrite;
    wire            doRead;
    integer         i;

    // ready comes from a flip-flop, computed from the next fill level
    assign inReady  = readyReg;
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr];
    assign doWrite  = inValid & inReady;
    assign doRead   = outValid & outReady;

    always @*
    begin
        next_count = count;
        if (doWrite & ~doRead)
            next_count = count + 1'b1;
        else if (doRead & ~doWrite)
            next_count = count - 1'b1;
    end

    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            wrPtr    <= {AW{1'b0}};
            rdPtr    <= {AW{1'b0}};
            count    <= {(AW+1){1'b0}};
            readyReg <= 1'b1;
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= {WIDTH{1'b0}};
        end
        else
        begin
            if (doWrite)
            begin
                mem[wrPtr] <= inData;
                wrPtr      <= wrPtr + 1'b1;
            end
            if (doRead)
                rdPtr <= rdPtr + 1'b1;
            count    <= next_count;
            readyReg <= (next_count != FULL_COUNT);
        end
    end
endmodule

module cfpc_port_config
(
    input  wire        clk_sys,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [31:0] rxFrameData,
    input  wire        rxFrameValid,
    output wire        rxFrameReady,
    output reg  [1:0]  portRun,
    output reg  [1:0]  portTxAllow,
    output reg  [1:0]  portAckAllow,
    output reg  [1:0]  portLegacyFd,
    output reg  [23:0] portArbRate,
    output reg  [23:0] portDataRate,
    output reg  [27:0] portSamplePoint
);
    localparam ST_STOP = 3'b001;
    localparam ST_RUN  = 3'b010;
    localparam ST_ERR  = 3'b100;

    // staged settings, written by software
    reg  [2:0]  ctrl [0:1];
    reg  [11:0] arbRate [0:1];
    reg  [11:0] dataRate [0:1];
    reg  [13:0] samplePoint [0:1];
    reg  [2:0]  state;
    reg  [1:0]  rangeErr;
    reg         fifoPop;
    wire [31:0] fifoData;
    wire        fifoValid;
    wire        access;
    wire        wrAccess;
    wire        stopped;
    wire [1:0]  badCfg;
    integer     p;
    integer     q;

    function inRange12;
        input [11:0] v;
        input [11:0] lo;
        input [11:0] hi;
        begin
            inRange12 = (v >= lo) && (v <= hi);
        end
    endfunction

    function cfgBad;
        input [11:0] arb;
        input [11:0] dat;
        input [13:0] sp;
        begin
            cfgBad = !inRange12(arb, `CFPC_ARB_MIN, `CFPC_ARB_MAX)
                  || !inRange12(dat, `CFPC_DATA_MIN, `CFPC_DATA_MAX)
                  || (sp < `CFPC_SP_MIN) || (sp > `CFPC_SP_MAX);
        end
    endfunction

    cfpc_fifo
    #(
        .WIDTH (`CFPC_FIFO_W),
        .DEPTH (`CFPC_FIFO_DEPTH),
        .AW    (`CFPC_FIFO_AW)
    )
    u_rxFifo
    (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .inData   (rxFrameData),
        .inValid  (rxFrameValid),
        .inReady  (rxFrameReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    assign access   = psel & penable & ~pready;
    assign wrAccess = access & pwrite;
    assign stopped  = (state != ST_RUN);
    assign badCfg   = {cfgBad(arbRate[1], dataRate[1], samplePoint[1]),
                       cfgBad(arbRate[0], dataRate[0], samplePoint[0])};

    // apb slave: one wait cycle, answer in the cycle after penable rises
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            fifoPop <= 1'b0;
            for (p = 0; p < 2; p = p + 1)
            begin
                ctrl[p]        <= 3'h0;
                arbRate[p]     <= `CFPC_ARB_RESET;
                dataRate[p]    <= `CFPC_DATA_RESET;
                samplePoint[p] <= `CFPC_SP_RESET;
            end
        end
        else
        begin
            pready  <= access;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            fifoPop <= 1'b0;
            if (access)
            begin
                if (paddr == `CFPC_OFS_CTRL0 || paddr == `CFPC_OFS_CTRL1)
                begin
                    if (wrAccess && stopped)
                        ctrl[paddr[4]] <= pwdata[2:0];
                    else if (wrAccess)
                        pslverr <= 1'b1;
                    prdata <= {29'h0, ctrl[paddr[4]]};
                end
                else if (paddr == `CFPC_OFS_ARB0 || paddr == `CFPC_OFS_ARB1)
                begin
                    if (wrAccess && stopped)
                        arbRate[paddr[4]] <= pwdata[11:0];
                    else if (wrAccess)
                        pslverr <= 1'b1;
                    prdata <= {20'h0, arbRate[paddr[4]]};
                end
                else if (paddr == `CFPC_OFS_DATA0 || paddr == `CFPC_OFS_DATA1)
                begin
                    if (wrAccess && stopped)
                        dataRate[paddr[4]] <= pwdata[11:0];
                    else if (wrAccess)
                        pslverr <= 1'b1;
                    prdata <= {20'h0, dataRate[paddr[4]]};
                end
                else if (paddr == `CFPC_OFS_SP0 || paddr == `CFPC_OFS_SP1)
                begin
                    if (wrAccess && stopped)
                        samplePoint[paddr[4]] <= pwdata[13:0];
                    else if (wrAccess)
                        pslverr <= 1'b1;
                    prdata <= {18'h0, samplePoint[paddr[4]]};
                end
                else if (paddr == `CFPC_OFS_CONNECT)
                    prdata <= 32'h00000000;
                else if (paddr == `CFPC_OFS_STATUS)
                    prdata <= {24'h0, fifoValid, 2'b00, rangeErr, state};
                else if (paddr == `CFPC_OFS_RXFIFO)
                begin
                    if (!pwrite)
                    begin
                        prdata  <= fifoData;
                        fifoPop <= fifoValid;
                    end
                end
                else
                    pslverr <= 1'b1;
            end
        end
    end

    // connect/disconnect sequencing and latching of active settings
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            state           <= ST_STOP;
            rangeErr        <= 2'b00;
            portRun         <= 2'b00;
            portTxAllow     <= 2'b00;
            portAckAllow    <= 2'b00;
            portLegacyFd    <= 2'b00;
            portArbRate     <= 24'h000000;
            portDataRate    <= 24'h000000;
            portSamplePoint <= 28'h0000000;
        end
        else
        begin
            case (state)
                ST_STOP, ST_ERR:
                begin
                    if (wrAccess && paddr == `CFPC_OFS_CONNECT
                        && pwdata[`CFPC_BIT_CONNECT])
                    begin
                        rangeErr <= badCfg;
                        if (badCfg != 2'b00)
                            state <= ST_ERR;
                        else
                        begin
                            state <= ST_RUN;
                            for (q = 0; q < 2; q = q + 1)
                            begin
                                portRun[q] <= ctrl[q][`CFPC_BIT_ENABLE];
                                portTxAllow[q] <= ctrl[q][`CFPC_BIT_ENABLE]
                                    & ~ctrl[q][`CFPC_BIT_MONITOR];
                                portAckAllow[q] <= ctrl[q][`CFPC_BIT_ENABLE]
                                    & ~ctrl[q][`CFPC_BIT_MONITOR];
                                portLegacyFd[q] <= ctrl[q][`CFPC_BIT_LEGACY];
                            end
                            portArbRate     <= {arbRate[1], arbRate[0]};
                            portDataRate    <= {dataRate[1], dataRate[0]};
                            portSamplePoint <= {samplePoint[1], samplePoint[0]};
                        end
                    end
                end
                ST_RUN:
                begin
                    if (wrAccess && paddr == `CFPC_OFS_CONNECT
                        && pwdata[`CFPC_BIT_DISCONNECT])
                    begin
                        state        <= ST_STOP;
                        portRun      <= 2'b00;
                        portTxAllow  <= 2'b00;
                        portAckAllow <= 2'b00;
                    end
                end
                default:
                    state <= ST_STOP;
            endcase
        end
    end
endmodule

// >>> verification/cfpc_port_config_assertions.sv
// cfpc_port_config_assertions.sv: timing and mode checks on the port block
// assumes: bound to cfpc_port_config, one clock
`timescale 1ns/100ps
`include "cfpc_consts.vh"
module cfpc_port_config_assertions
(
    input logic        clk_sys,
    input logic        reset,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic        pready,
    input logic        pslverr,
    input logic [1:0]  portRun,
    input logic [1:0]  portTxAllow,
    input logic [1:0]  portAckAllow,
    input logic [23:0] portArbRate,
    input logic [23:0] portDataRate,
    input logic [27:0] portSamplePoint
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence taken;
        psel && penable && !pready;
    endsequence
    sequence answer;
        pready ##1 !pready;
    endsequence
    pready_one_a: assert property (taken |=> answer)
        else $error("pready not one pulse after access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside pready");
    tx_needs_run_a: assert property ((portTxAllow & ~portRun) == 2'b00)
        else $error("transmit allowed on stopped port");
    ack_is_tx_a: assert property (portAckAllow == portTxAllow)
        else $error("ack allow differs from transmit allow");
    run_on_connect_a: assert property ($rose(portRun[0]) |->
        $past(psel && penable && pwrite && paddr == `CFPC_OFS_CONNECT && pwdata[0]))
        else $error("port started without connect");
    timing_frozen_a: assert property (portRun != 2'b00 && $past(portRun) != 2'b00
        |-> $stable(portArbRate) && $stable(portDataRate) && $stable(portSamplePoint))
        else $error("bit timing changed while running");
    arb_range_a: assert property (portRun[0] |->
        portArbRate[11:0] inside {[`CFPC_ARB_MIN:`CFPC_ARB_MAX]})
        else $error("arbitration rate out of range");
    data_range_a: assert property (portRun[0] |->
        portDataRate[11:0] inside {[`CFPC_DATA_MIN:`CFPC_DATA_MAX]})
        else $error("data rate out of range");
    sp_range_a: assert property (portRun[0] |->
        portSamplePoint[13:0] inside {[`CFPC_SP_MIN:`CFPC_SP_MAX]})
        else $error("sample point out of range");
endmodule

// >>> verification/cfpc_can_node.sv
// cfpc_can_node.sv: CAN side frame source for the receive buffer
// assumes: clk_sys domain, word held until ready
`timescale 1ns/100ps
module cfpc_can_node
(
    input  logic        clk_sys,
    input  logic        rxFrameReady,
    output logic [31:0] rxFrameData,
    output logic        rxFrameValid
);
    initial
    begin
        rxFrameValid = 1'b0;
        rxFrameData  = 32'h0000_0000;
    end
    // idle gap then one word; data inverted while idle
    task send(input logic [31:0] d, input int gap);
        repeat (gap + 1) @(posedge clk_sys);
        rxFrameValid <= 1'b1;
        rxFrameData  <= d;
        do @(posedge clk_sys); while (rxFrameReady !== 1'b1);
        rxFrameValid <= 1'b0;
        rxFrameData  <= ~d;
    endtask
endmodule

// >>> verification/testbench.sv
// testbench.sv: APB checks of port modes, timing latch, range refusal, receive buffer
// assumes: design, checker and frame source compiled first
`timescale 1ns/100ps
`include "cfpc_consts.vh"
module testbench;
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata, rxFrameData, fr[5];
    logic        pready, pslverr, rxFrameValid, rxFrameReady;
    logic [1:0]  portRun, portTxAllow, portAckAllow, portLegacyFd;
    logic [23:0] portArbRate, portDataRate;
    logic [27:0] portSamplePoint;
    logic [11:0] arb[2], dat[2];
    logic [13:0] sp[2];
    logic [33:0] noteQ[$];
    logic [33:0] n;
    int          errors = 0;
    int          check_count = 0;
    int          badV[6] = '{9, 1001, 99, 3001, 0, 10000};
    cfpc_port_config dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxFrameData(rxFrameData), .rxFrameValid(rxFrameValid),
        .rxFrameReady(rxFrameReady), .portRun(portRun), .portTxAllow(portTxAllow),
        .portAckAllow(portAckAllow), .portLegacyFd(portLegacyFd), .portArbRate(portArbRate),
        .portDataRate(portDataRate), .portSamplePoint(portSamplePoint));
    cfpc_can_node node (.clk_sys(clk_sys), .rxFrameReady(rxFrameReady),
        .rxFrameData(rxFrameData), .rxFrameValid(rxFrameValid));
    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_of_test;
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // note = {check data, expected error, expected data}
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
        noteQ.push_back(e);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic err);
        apb(1'b1, a, d, {1'b0, err, 32'h0000_0000});
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x, input logic err);
        apb(1'b0, a, 32'h0000_0000, {1'b1, err, x});
    endtask
    always @(posedge clk_sys)
        if (psel && penable && pready === 1'b1)
        begin
            n = noteQ.pop_front();
            chk("pslverr", {31'h0, pslverr}, {31'h0, n[32]});
            if (n[33])
                chk("prdata", prdata, n[31:0]);
        end
    initial
    begin
        #(25 * 20000);
        errors++;
        end_of_test;
    end
    initial
    begin
        void'($urandom(80826));
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        rd(`CFPC_OFS_ARB0, {20'h0, `CFPC_ARB_RESET}, 1'b0);
        rd(`CFPC_OFS_DATA1, {20'h0, `CFPC_DATA_RESET}, 1'b0);
        rd(`CFPC_OFS_SP0, {18'h0, `CFPC_SP_RESET}, 1'b0);
        rd(`CFPC_OFS_STATUS, 32'h0000_0001, 1'b0);
        rd(12'h02C, 32'h0000_0000, 1'b1);
        for (int p = 0; p < 2; p++)
        begin
            arb[p] = 12'(10 + $urandom % 991);
            dat[p] = 12'(100 + $urandom % 2901);
            sp[p]  = 14'(7500 + $urandom % 1251);
            wr(`CFPC_OFS_ARB0 + 12'(p * 16), {20'h0, arb[p]}, 1'b0);
            wr(`CFPC_OFS_DATA0 + 12'(p * 16), {20'h0, dat[p]}, 1'b0);
            wr(`CFPC_OFS_SP0 + 12'(p * 16), {18'h0, sp[p]}, 1'b0);
        end
        wr(`CFPC_OFS_CTRL0, 32'h0000_0005, 1'b0);
        for (int m = 0; m < 8; m++)
        begin
            wr(`CFPC_OFS_CTRL1, 32'(m), 1'b0);
            wr(`CFPC_OFS_CONNECT, 32'h0000_0001, 1'b0);
            chk("run", 32'(portRun), {30'h0, m[0], 1'b1});
            chk("tx", 32'(portTxAllow), {30'h0, m[0] & ~m[1], 1'b1});
            chk("ack", 32'(portAckAllow), {30'h0, m[0] & ~m[1], 1'b1});
            chk("legacy", {30'h0, portLegacyFd}, {30'h0, m[2], 1'b1});
            chk("arb", 32'(portArbRate), {8'h0, arb[1], arb[0]});
            chk("data", 32'(portDataRate), {8'h0, dat[1], dat[0]});
            chk("sp", 32'(portSamplePoint), {4'h0, sp[1], sp[0]});
            wr(`CFPC_OFS_ARB0, 32'h0000_0064, 1'b1);
            rd(`CFPC_OFS_ARB0, {20'h0, arb[0]}, 1'b0);
            wr(`CFPC_OFS_CONNECT, 32'h0000_0002, 1'b0);
            chk("stop", 32'(portRun), 32'h0);
        end
        for (int i = 0; i < 5; i++)
            fr[i] = $urandom;
        fork
            for (int i = 0; i < 5; i++)
                node.send(fr[i], $urandom % 3);
        join_none
        repeat (30) @(posedge clk_sys);
        chk("full", {31'h0, rxFrameReady}, 32'h0);
        rd(`CFPC_OFS_STATUS, 32'h0000_0081, 1'b0);
        for (int i = 0; i < 5; i++)
            rd(`CFPC_OFS_RXFIFO, fr[i], 1'b0);
        chk("empty", {31'h0, rxFrameReady}, 32'h1);
        for (int b = 0; b < 6; b++)
        begin
            paddr <= paddr;
            wr(b < 2 ? `CFPC_OFS_ARB0 : b < 4 ? `CFPC_OFS_DATA0 : `CFPC_OFS_SP0, badV[b], 1'b0);
            wr(`CFPC_OFS_CONNECT, 32'h0000_0001, 1'b0);
            chk("refused", 32'(portRun), 32'h0);
            rd(`CFPC_OFS_STATUS, 32'h0000_000C, 1'b0);
            wr(b < 2 ? `CFPC_OFS_ARB0 : b < 4 ? `CFPC_OFS_DATA0 : `CFPC_OFS_SP0,
                b < 2 ? {20'h0, arb[0]} : b < 4 ? {20'h0, dat[0]} : {18'h0, sp[0]}, 1'b0);
        end
        wr(`CFPC_OFS_CONNECT, 32'h0000_0001, 1'b0);
        chk("restart", 32'(portRun), 32'h3);
        end_of_test;
    end
endmodule
bind cfpc_port_config cfpc_port_config_assertions chk_i (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .portRun(portRun), .portTxAllow(portTxAllow),
    .portAckAllow(portAckAllow), .portArbRate(portArbRate), .portDataRate(portDataRate),
    .portSamplePoint(portSamplePoint));
